// ---- common/iq_power_detector_pkg.sv ----
package iq_power_detector_pkg;

  // Register offsets
  localparam logic [11:0] ADDR_LIMIT_LOW  = 12'h060;
  localparam logic [11:0] ADDR_LIMIT_HIGH = 12'h061;
  localparam logic [11:0] ADDR_AVG_CTRL   = 12'h062;
  localparam logic [11:0] ADDR_POWER_LOW  = 12'h063;
  localparam logic [11:0] ADDR_POWER_HIGH = 12'h064;

  // Field layout
  localparam int LIMIT_W      = 13;
  localparam int LOW_W        = 8;
  localparam int HIGH_W       = 5;
  localparam int EXP_W        = 4;
  localparam int ENABLE_BIT   = 7;
  localparam int DATA_MSBS    = 6;
  localparam int SUM_W        = 2 * DATA_MSBS;
  localparam int SHIFT_W      = 5;

  // Averaging window: 2^(EXP_BASE + exponent), exponent 0..EXP_MAX
  localparam logic [SHIFT_W-1:0] EXP_BASE = 5'h09;
  localparam logic [EXP_W-1:0]   EXP_MAX  = 4'ha;
  localparam int                 ACC_W    = SUM_W + 19;

  // Reset values
  localparam logic [LIMIT_W-1:0] RST_LIMIT  = 13'h0000;
  localparam logic               RST_ENABLE = 1'b0;
  localparam logic [EXP_W-1:0]   RST_EXP    = 4'h0;

endpackage

// ---- rtl/iq_power_square.sv ----
`timescale 1ns/100ps
module iq_power_square #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input  wire logic                                   i_ref_clk,
  input  wire logic                                   i_rst_n,
  // Sample in
  input  wire logic                                   i_valid,
  input  wire logic [SAMPLE_W-1:0]                    i_i_sample,
  input  wire logic [SAMPLE_W-1:0]                    i_q_sample,
  // Squared sum out
  output logic                                        o_valid,
  output logic [iq_power_detector_pkg::SUM_W-1:0]     o_sum
);

  localparam int MSBS = iq_power_detector_pkg::DATA_MSBS;
  localparam int SW   = iq_power_detector_pkg::SUM_W;

  // Only the top bits matter; keeps the squarers tiny
  wire logic signed [MSBS-1:0] i_top = i_i_sample[SAMPLE_W-1 -: MSBS];
  wire logic signed [MSBS-1:0] q_top = i_q_sample[SAMPLE_W-1 -: MSBS];
  wire logic signed [SW-1:0]   i_sq  = i_top * i_top;
  wire logic signed [SW-1:0]   q_sq  = q_top * q_top;
  wire logic [SW-1:0]          sum_w = $unsigned(i_sq) + $unsigned(q_sq);

  // One pipeline stage
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'h0;
      o_sum   <= '0;
    end else begin
      o_valid <= i_valid;
      o_sum   <= i_valid ? sum_w : o_sum;
    end
  end

  property p_top_bits_square;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_valid |=> (o_sum == SW'($past(i_top) * $past(i_top)) + SW'($past(q_top) * $past(q_top))) && o_sum <= 12'h800;
  endproperty
  a_top_bits_square: assert property (p_top_bits_square) else $error("power sum not from top data bits");

endmodule // iq_power_square

// ---- rtl/iq_power_detector.sv ----
`timescale 1ns/100ps
module iq_power_detector #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input  wire logic                                     i_ref_clk,
  input  wire logic                                     i_rst_n,
  // Sample stream from link receive datapath
  input  wire logic                                     i_sample_valid,
  input  wire logic [SAMPLE_W-1:0]                      i_i_sample,
  input  wire logic [SAMPLE_W-1:0]                      i_q_sample,
  // Register port
  input  wire logic                                     i_reg_wr,
  input  wire logic                                     i_reg_rd,
  input  wire logic [11:0]                              i_reg_addr,
  input  wire logic [7:0]                               i_reg_wdata,
  output logic [7:0]                                    o_reg_rdata,
  output logic                                          o_reg_rvalid,
  // Power-detect interrupt handshake
  input  wire logic                                     i_irq_clear,
  output logic                                          o_power_event,
  // Status
  output logic                                          o_overpower_flag,
  output logic [iq_power_detector_pkg::LIMIT_W-1:0]     o_measured_power
);

  localparam int LW = iq_power_detector_pkg::LIMIT_W;
  localparam int SW = iq_power_detector_pkg::SUM_W;
  localparam int AW = iq_power_detector_pkg::ACC_W;
  localparam int EW = iq_power_detector_pkg::EXP_W;
  localparam int HW = iq_power_detector_pkg::HIGH_W;

  // Control and state registers
  logic [LW-1:0] limit_q;
  logic          enable_q;
  logic [EW-1:0] exp_q;
  logic [AW-1:0] acc_q;
  logic [AW-1:0] acc_d;
  logic          hold_q;
  logic          hold_d;
  logic [LW-1:0] peak_q;
  logic [LW-1:0] peak_d;
  logic [HW-1:0] shadow_q;
  logic          sq_valid;
  logic [SW-1:0] sq_sum;

  // Squarer stage
  iq_power_square #(
    .SAMPLE_W (SAMPLE_W)
  ) u_square (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_valid    (i_sample_valid),
    .i_i_sample (i_i_sample),
    .i_q_sample (i_q_sample),
    .o_valid    (sq_valid),
    .o_sum      (sq_sum)
  );

  // Register decode
  wire logic wr_limit_low  = i_reg_wr && (i_reg_addr == iq_power_detector_pkg::ADDR_LIMIT_LOW);
  wire logic wr_limit_high = i_reg_wr && (i_reg_addr == iq_power_detector_pkg::ADDR_LIMIT_HIGH);
  wire logic wr_ctrl       = i_reg_wr && (i_reg_addr == iq_power_detector_pkg::ADDR_AVG_CTRL);
  wire logic rd_power_low  = i_reg_rd && (i_reg_addr == iq_power_detector_pkg::ADDR_POWER_LOW);
  // Out-of-range exponents would overflow the accumulator, so clamp to the top value
  wire logic [EW-1:0] exp_wr = (i_reg_wdata[EW-1:0] > iq_power_detector_pkg::EXP_MAX) ?
                               iq_power_detector_pkg::EXP_MAX : i_reg_wdata[EW-1:0];

  // Readback mux; reserved bits read zero
  wire logic [7:0] rmux_w =
    (i_reg_addr == iq_power_detector_pkg::ADDR_LIMIT_LOW)  ? limit_q[7:0] :
    (i_reg_addr == iq_power_detector_pkg::ADDR_LIMIT_HIGH) ? {3'h0, limit_q[LW-1:8]} :
    (i_reg_addr == iq_power_detector_pkg::ADDR_AVG_CTRL)   ? {enable_q, 3'h0, exp_q} :
    (i_reg_addr == iq_power_detector_pkg::ADDR_POWER_LOW)  ? peak_q[7:0] :
    (i_reg_addr == iq_power_detector_pkg::ADDR_POWER_HIGH) ? {3'h0, shadow_q} : 8'h00;

  // Exponential moving average with time constant 2^(9+exp)
  wire logic [iq_power_detector_pkg::SHIFT_W-1:0] shift_w =
    iq_power_detector_pkg::EXP_BASE + {1'h0, exp_q};
  wire logic [AW-1:0] decay_w = acc_q >> shift_w;
  wire logic [LW-1:0] avg_w   = LW'(acc_q >> shift_w);
  wire logic          cross_w = enable_q && (avg_w > limit_q);

  // Accumulator next value; cleared while disabled so a restart begins fresh
  always_comb begin
    if (!enable_q) begin
      acc_d = '0;
    end else if (sq_valid) begin
      acc_d = acc_q + AW'(sq_sum) - decay_w;
    end else begin
      acc_d = acc_q;
    end
  end

  // Peak hold: a new crossing wins over a clear in the same cycle
  always_comb begin
    hold_d = cross_w ? 1'h1 : (i_irq_clear ? 1'h0 : hold_q);
    if (hold_q && !(i_irq_clear && !cross_w)) begin
      peak_d = (avg_w > peak_q) ? avg_w : peak_q;
    end else begin
      peak_d = avg_w;
    end
  end

  // Control registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      limit_q  <= iq_power_detector_pkg::RST_LIMIT;
      enable_q <= iq_power_detector_pkg::RST_ENABLE;
      exp_q    <= iq_power_detector_pkg::RST_EXP;
    end else begin
      if (wr_limit_low)  limit_q[7:0]    <= i_reg_wdata;
      if (wr_limit_high) limit_q[LW-1:8] <= i_reg_wdata[HW-1:0];
      if (wr_ctrl) begin
        enable_q <= i_reg_wdata[iq_power_detector_pkg::ENABLE_BIT];
        exp_q    <= exp_wr;
      end
    end
  end

  // Datapath state
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q            <= '0;
      hold_q           <= 1'h0;
      peak_q           <= '0;
      o_overpower_flag <= 1'h0;
      o_power_event    <= 1'h0;
    end else begin
      acc_q            <= acc_d;
      hold_q           <= hold_d;
      peak_q           <= peak_d;
      o_overpower_flag <= cross_w;
      o_power_event    <= cross_w && !o_overpower_flag;
    end
  end

  // Read port; high byte snapshot keeps a low-then-high read pair consistent
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'h0;
      shadow_q     <= '0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) o_reg_rdata <= rmux_w;
      if (rd_power_low) shadow_q <= peak_q[LW-1:8];
    end
  end

  assign o_measured_power = peak_q;

  property p_disabled_idle;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !enable_q |=> acc_q == '0 ##1 (!o_overpower_flag || enable_q);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("power computed while disabled");

  property p_exp_range;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      exp_q <= iq_power_detector_pkg::EXP_MAX;
  endproperty
  a_exp_range: assert property (p_exp_range) else $error("averaging exponent above ten");

  property p_live_average;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!hold_q && !cross_w) |=> o_measured_power == $past(avg_w);
  endproperty
  a_live_average: assert property (p_live_average) else $error("measured power not tracking average");

  property p_peak_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (hold_q && !i_irq_clear) |=> hold_q && o_measured_power >= $past(o_measured_power);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak hold lost before clear");

  property p_flag_on_cross;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (enable_q && avg_w > limit_q) |=> o_overpower_flag ##0 hold_q;
  endproperty
  a_flag_on_cross: assert property (p_flag_on_cross) else $error("overpower flag missing on crossing");

  property p_flag_only_cross;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(o_overpower_flag) |-> $past(avg_w) > $past(limit_q);
  endproperty
  a_flag_only_cross: assert property (p_flag_only_cross) else $error("overpower flag without crossing");

  property p_limit_split;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_limit_low && !wr_limit_high) |=> limit_q[7:0] == $past(i_reg_wdata) && $stable(limit_q[LW-1:8]);
  endproperty
  a_limit_split: assert property (p_limit_split) else $error("limit low byte write wrong");

  property p_clear_release;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_irq_clear && !cross_w) |=> !hold_q && o_measured_power == $past(avg_w);
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("hold not released by clear");

  property p_read_answer;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_reg_rd |=> o_reg_rvalid ##1 !o_reg_rvalid || $past(i_reg_rd);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer not one cycle after request");

endmodule // iq_power_detector

// ---- verif/iq_sample_source.sv ----
`timescale 1ns/100ps
// Upstream I/Q source, one pair per cycle
module iq_sample_source (
  // Clock
  input  wire logic        i_ref_clk,
  // Sample stream
  output logic             o_valid,
  output logic [15:0]      o_i,
  output logic [15:0]      o_q
);
  // Pair changes just after the falling edge
  task automatic push(input logic [15:0] i, input logic [15:0] q);
    @(negedge i_ref_clk);
    o_valid = 1'b1;
    o_i     = i;
    o_q     = q;
  endtask
  // Idle lines scramble so no stale pair can pass
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge i_ref_clk);
      o_valid = 1'b0;
      o_i     = ~o_i;
      o_q     = ~o_q;
    end
  endtask
  initial begin
    o_valid = 1'b0;
    o_i     = 16'h0000;
    o_q     = 16'h0000;
  end
endmodule // iq_sample_source

// ---- verif/iq_power_detector_tb.sv ----
`timescale 1ns/100ps
module iq_power_detector_tb;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0;
  logic        vld, evt, flag, rvld;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [15:0] si, sq;
  logic [12:0] mpow;
  int bad_count = 0, comparisons = 0, events = 0;
  int acc = 0, avg = 0, peak = 0, lim = 0, sh = 9, en = 0, hold = 0;
  int exp_pow[$], exp_flag[$];
  logic [2:0] vld_pipe = 3'h0;
  always #2 clk = ~clk;
  iq_sample_source src_u (.i_ref_clk(clk), .o_valid(vld), .o_i(si), .o_q(sq));
  iq_power_detector dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sample_valid(vld), .i_i_sample(si),
    .i_q_sample(sq), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvld), .i_irq_clear(clr), .o_power_event(evt),
    .o_overpower_flag(flag), .o_measured_power(mpow));
  // Sampled mid-cycle, away from the launching edge
  always @(negedge clk) if (evt === 1'b1) events++;
  // A taken pair shows on the outputs after the third rising edge
  always @(posedge clk) vld_pipe <= {vld_pipe[1:0], vld};
  // Every result against the model, so a single bad sample cannot hide
  always @(negedge clk) begin
    if (vld_pipe[2] === 1'b1) begin
      chk("power_live", exp_pow.pop_front(), {3'b000, mpow});
      chk("flag_live", exp_flag.pop_front(), {15'h0000, flag});
    end
  end
  task automatic chk(input string name, input int exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp[15:0]) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input int exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk("rvalid", 1, {15'h0000, rvld});
    chk("rdata", exp, {8'h00, rdata});
  endtask
  // Reference model: moving average on six top bits, peak hold
  task automatic feed(input int n, input logic rnd, input logic [15:0] v);
    logic [15:0] i, q;
    int ii, qq;
    repeat (n) begin
      i = rnd ? 16'($urandom) : v;
      q = rnd ? 16'($urandom) : v;
      src_u.push(i, q);
      ii = $signed(i[15:10]);
      qq = $signed(q[15:10]);
      if (en) acc = acc + ii * ii + qq * qq - (acc >>> sh);
      avg = acc >>> sh;
      if (en && avg > lim) hold = 1;
      if (hold && avg > peak) peak = avg;
      exp_pow.push_back(hold ? peak : avg);
      exp_flag.push_back(int'(en && avg > lim));
    end
  endtask
  task automatic outs();
    src_u.idle(5);
    chk("power", hold ? peak : avg, {3'b000, mpow});
    chk("flag", int'(en && avg > lim), {15'h0000, flag});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(51));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 12'h060; a <= 12'h065; a++) rd_chk(12'(a), 0);
    wr_reg(12'h060, 8'hff);
    wr_reg(12'h061, 8'hff);
    lim = 13'h1fff;
    rd_chk(12'h061, 8'h1f);
    rd_chk(12'h060, 8'hff);
    wr_reg(12'h063, 8'h55);
    rd_chk(12'h063, 0);
    wr_reg(12'h062, 8'h0c);
    rd_chk(12'h062, 8'h0a);
    feed(50, 1'b1, 16'h0000);
    outs();
    wr_reg(12'h062, 8'h81);
    en = 1;
    sh = 10;
    feed(400, 1'b1, 16'h0000);
    outs();
    rd_chk(12'h063, avg & 8'hff);
    rd_chk(12'h064, avg >> 8);
    wr_reg(12'h062, 8'h00);
    en = 0;
    acc = 0;
    avg = 0;
    wr_reg(12'h061, 8'h01);
    wr_reg(12'h060, 8'h00);
    lim = 13'h0100;
    wr_reg(12'h062, 8'h80);
    en = 1;
    sh = 9;
    feed(300, 1'b0, 16'h8000);
    outs();
    chk("events", 1, 16'(events));
    feed(200, 1'b0, 16'h0000);
    outs();
    wr_reg(12'h061, 8'h1f);
    wr_reg(12'h060, 8'hff);
    lim = 13'h1fff;
    outs();
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    hold = 0;
    peak = 0;
    outs();
    feed(100, 1'b0, 16'h0000);
    outs();
    wrap_up();
  end
endmodule // iq_power_detector_tb
